//--- common/trig_seq_pkg.sv
package trig_seq_pkg;
  localparam int NUM_LINES = 6;
  localparam int LINE_NUM_W = 3;
  localparam int CNT_W = 8;
  localparam int TIMER_W = 12;
  localparam int CLK_PERIOD_PS = 4000;
  // Trigger line numbers used in the two-unit scan, counted from one.
  localparam logic [2:0] LINE_METER_DONE = 3'h1;
  localparam logic [2:0] LINE_METER_TRIG = 3'h2;
  localparam logic [2:0] LINE_HAND_BACK = 3'h3;
  localparam logic [2:0] LINE_HAND_OVER = 3'h4;
  localparam logic [2:0] LINE_ARM_A_IN = 3'h5;
  localparam logic [2:0] LINE_ARM_A_OUT = 3'h6;
  // Low time of an emitted trigger, relay settle time and meter conversion time.
  localparam int TRIG_PULSE_NS = 1000;
  localparam int SETTLE_NS = 2000;
  localparam int MEASURE_NS = 4000;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MEASURE_CYC = (MEASURE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEFAULT_LIST_LEN = 21;
  localparam int DEFAULT_STORE_DEPTH = 80;
  localparam logic [NUM_LINES-1:0] ALL_RELEASED = 6'h3F;
endpackage

//--- common/trig_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface trig_bus_if;
  import trig_seq_pkg::*;
  logic [NUM_LINES-1:0] dev_out;
  logic [NUM_LINES-1:0] dev_oe_n;
  logic [NUM_LINES-1:0] oth_out;
  logic [NUM_LINES-1:0] oth_oe_n;
  // Release mask of any further party on the wired lines, set by the bench.
  logic [NUM_LINES-1:0] aux_oe_n;
  logic [NUM_LINES-1:0] line;
  // A line is low when any party enables its low drive, else pulled up.
  assign line = dev_oe_n & oth_oe_n & aux_oe_n;
  modport device (input line, output dev_out, output dev_oe_n);
  modport other (input line, output oth_out, output oth_oe_n);
endinterface
`default_nettype wire

//--- core/scan_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer #(
  parameter int SETTLE_CYCLES = trig_seq_pkg::SETTLE_CYC,
  parameter int PULSE_CYCLES = trig_seq_pkg::TRIG_PULSE_CYC
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Trigger lines.
  trig_bus_if.device bus,
  // Start and layer sources.
  input wire logic step_in,
  input wire logic arm_src_line_in,
  input wire logic scan_src_line_in,
  input wire logic chan_src_line_in,
  input wire logic arm_bypass_in,
  input wire logic scan_bypass_in,
  input wire logic chan_bypass_in,
  // Line numbers and counts.
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] arm_in_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] arm_out_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] scan_in_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] scan_out_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] chan_in_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] chan_out_line_in,
  input wire logic [trig_seq_pkg::CNT_W-1:0] arm_count_in,
  input wire logic [trig_seq_pkg::CNT_W-1:0] scan_count_in,
  input wire logic [trig_seq_pkg::CNT_W-1:0] list_len_in,
  // Relay and status.
  output logic close_out,
  output logic [trig_seq_pkg::CNT_W-1:0] close_idx_out,
  output logic all_open_out,
  output logic idle_out,
  output logic arm_wait_out,
  output logic scan_wait_out
);
  import trig_seq_pkg::*;

  typedef enum {
    ST_IDLE, ST_ARM_WAIT, ST_SCAN_WAIT, ST_CHAN_WAIT, ST_SETTLE,
    ST_CHAN_OUT, ST_CHAN_END, ST_SCAN_OUT, ST_SCAN_END, ST_ARM_OUT, ST_ARM_END
  } seq_state_t;

  seq_state_t state_reg, state_next;
  logic [NUM_LINES-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [NUM_LINES-1:0] rise;
  logic [NUM_LINES-1:0] oe_n_reg, oe_n_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [CNT_W-1:0] arm_cnt_reg, arm_cnt_next;
  logic [CNT_W-1:0] scan_cnt_reg, scan_cnt_next;
  logic [CNT_W-1:0] chan_idx_reg, chan_idx_next;
  logic arm_first_reg, arm_first_next;
  logic scan_first_reg, scan_first_next;
  logic chan_first_reg, chan_first_next;
  logic close_reg, close_next;
  logic all_open_reg, all_open_next;
  logic [CNT_W-1:0] close_idx_reg, close_idx_next;

  function automatic logic pick(input logic [NUM_LINES-1:0] vec,
                                input logic [LINE_NUM_W-1:0] num);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (num == LINE_NUM_W'(i + 1)) begin
        r = vec[i];
      end
    end
    return r;
  endfunction

  function automatic logic [NUM_LINES-1:0] pull(input logic [LINE_NUM_W-1:0] num);
    logic [NUM_LINES-1:0] r;
    r = ALL_RELEASED;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (num == LINE_NUM_W'(i + 1)) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      sync1_reg <= ALL_RELEASED;
      sync2_reg <= ALL_RELEASED;
      prev_reg <= ALL_RELEASED;
    end else begin
      sync1_reg <= bus.line;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;

  always_comb begin
    state_next = state_reg;
    oe_n_next = ALL_RELEASED;
    timer_next = timer_reg;
    arm_cnt_next = arm_cnt_reg;
    scan_cnt_next = scan_cnt_reg;
    chan_idx_next = chan_idx_reg;
    arm_first_next = arm_first_reg;
    scan_first_next = scan_first_reg;
    chan_first_next = chan_first_reg;
    close_next = 1'b0;
    all_open_next = 1'b0;
    close_idx_next = close_idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (step_in) begin
          arm_first_next = 1'b1;
          scan_first_next = 1'b1;
          arm_cnt_next = '0;
          state_next = ST_ARM_WAIT;
        end
      end
      ST_ARM_WAIT: begin
        if (!arm_src_line_in || (arm_bypass_in && arm_first_reg) ||
            pick(rise, arm_in_line_in)) begin
          arm_first_next = 1'b0;
          // Each entry from the arm layer is a first pass of the scan layer.
          scan_first_next = 1'b1;
          scan_cnt_next = '0;
          state_next = ST_SCAN_WAIT;
        end
      end
      ST_SCAN_WAIT: begin
        if (!scan_src_line_in || (scan_bypass_in && scan_first_reg) ||
            pick(rise, scan_in_line_in)) begin
          scan_first_next = 1'b0;
          chan_idx_next = '0;
          chan_first_next = 1'b1;
          state_next = ST_CHAN_WAIT;
        end
      end
      ST_CHAN_WAIT: begin
        if (!chan_src_line_in || (chan_bypass_in && chan_first_reg) ||
            pick(rise, chan_in_line_in)) begin
          chan_first_next = 1'b0;
          close_next = 1'b1;
          close_idx_next = chan_idx_reg;
          all_open_next = (chan_idx_reg == list_len_in - 1'b1);
          timer_next = TIMER_W'(SETTLE_CYCLES - 1);
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (timer_reg == '0) begin
          if (chan_src_line_in) begin
            timer_next = TIMER_W'(PULSE_CYCLES - 1);
            oe_n_next = pull(chan_out_line_in);
            state_next = ST_CHAN_OUT;
          end else begin
            state_next = ST_CHAN_END;
          end
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      ST_CHAN_OUT: begin
        if (timer_reg == '0) begin
          state_next = ST_CHAN_END;
        end else begin
          oe_n_next = pull(chan_out_line_in);
          timer_next = timer_reg - 1'b1;
        end
      end
      ST_CHAN_END: begin
        if (chan_idx_reg >= list_len_in - 1'b1) begin
          if (scan_src_line_in && scan_bypass_in) begin
            timer_next = TIMER_W'(PULSE_CYCLES - 1);
            oe_n_next = pull(scan_out_line_in);
            state_next = ST_SCAN_OUT;
          end else begin
            state_next = ST_SCAN_END;
          end
        end else begin
          chan_idx_next = chan_idx_reg + 1'b1;
          state_next = ST_CHAN_WAIT;
        end
      end
      ST_SCAN_OUT: begin
        if (timer_reg == '0) begin
          state_next = ST_SCAN_END;
        end else begin
          oe_n_next = pull(scan_out_line_in);
          timer_next = timer_reg - 1'b1;
        end
      end
      ST_SCAN_END: begin
        // last scan pass ends arm layer
        if (scan_cnt_reg + 1'b1 < scan_count_in) begin
          scan_cnt_next = scan_cnt_reg + 1'b1;
          state_next = ST_SCAN_WAIT;
        end else if (arm_src_line_in && arm_bypass_in) begin
          timer_next = TIMER_W'(PULSE_CYCLES - 1);
          oe_n_next = pull(arm_out_line_in);
          state_next = ST_ARM_OUT;
        end else begin
          state_next = ST_ARM_END;
        end
      end
      ST_ARM_OUT: begin
        if (timer_reg == '0) begin
          state_next = ST_ARM_END;
        end else begin
          oe_n_next = pull(arm_out_line_in);
          timer_next = timer_reg - 1'b1;
        end
      end
      ST_ARM_END: begin
        if (arm_cnt_reg + 1'b1 < arm_count_in) begin
          arm_cnt_next = arm_cnt_reg + 1'b1;
          state_next = ST_ARM_WAIT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      oe_n_reg <= ALL_RELEASED;
      timer_reg <= '0;
      arm_cnt_reg <= '0;
      scan_cnt_reg <= '0;
      chan_idx_reg <= '0;
      arm_first_reg <= 1'b0;
      scan_first_reg <= 1'b0;
      chan_first_reg <= 1'b0;
      close_reg <= 1'b0;
      all_open_reg <= 1'b0;
      close_idx_reg <= '0;
    end else begin
      state_reg <= state_next;
      oe_n_reg <= oe_n_next;
      timer_reg <= timer_next;
      arm_cnt_reg <= arm_cnt_next;
      scan_cnt_reg <= scan_cnt_next;
      chan_idx_reg <= chan_idx_next;
      arm_first_reg <= arm_first_next;
      scan_first_reg <= scan_first_next;
      chan_first_reg <= chan_first_next;
      close_reg <= close_next;
      all_open_reg <= all_open_next;
      close_idx_reg <= close_idx_next;
    end
  end

  // Open-drain: the driven level is always low, only the enable moves.
  assign bus.dev_out = '0;
  assign bus.dev_oe_n = oe_n_reg;
  assign close_out = close_reg;
  assign close_idx_out = close_idx_reg;
  assign all_open_out = all_open_reg;
  assign idle_out = (state_reg == ST_IDLE);
  assign arm_wait_out = (state_reg == ST_ARM_WAIT);
  assign scan_wait_out = (state_reg == ST_SCAN_WAIT);
endmodule
`default_nettype wire

//--- core/meter_trigger_end.sv
`timescale 1ns/1ps
`default_nettype none
module meter_trigger_end #(
  parameter int MEASURE_CYCLES = trig_seq_pkg::MEASURE_CYC,
  parameter int PULSE_CYCLES = trig_seq_pkg::TRIG_PULSE_CYC,
  parameter int STORE_DEPTH = trig_seq_pkg::DEFAULT_STORE_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Trigger lines.
  trig_bus_if.other bus,
  // Setup.
  input wire logic start_in,
  input wire logic src_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] in_line_in,
  input wire logic [trig_seq_pkg::LINE_NUM_W-1:0] out_line_in,
  input wire logic [trig_seq_pkg::CNT_W-1:0] list_len_in,
  // Readings.
  output logic store_out,
  output logic [trig_seq_pkg::CNT_W-1:0] store_idx_out,
  output logic ignored_out,
  output logic waiting_out
);
  import trig_seq_pkg::*;

  typedef enum {M_IDLE, M_WAIT, M_MEAS, M_OUT} meter_state_t;

  meter_state_t state_reg, state_next;
  logic [NUM_LINES-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [NUM_LINES-1:0] fall;
  logic [NUM_LINES-1:0] oe_n_reg, oe_n_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [CNT_W-1:0] trig_idx_reg, trig_idx_next;
  logic [CNT_W-1:0] store_idx_reg, store_idx_next;
  logic store_reg, store_next;
  logic ignored_reg, ignored_next;
  logic in_fall;

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      sync1_reg <= ALL_RELEASED;
      sync2_reg <= ALL_RELEASED;
      prev_reg <= ALL_RELEASED;
    end else begin
      sync1_reg <= bus.line;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign fall = prev_reg & ~sync2_reg;

  always_comb begin
    in_fall = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (in_line_in == LINE_NUM_W'(i + 1)) begin
        in_fall = fall[i];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    oe_n_next = ALL_RELEASED;
    timer_next = timer_reg;
    trig_idx_next = trig_idx_reg;
    store_idx_next = store_idx_reg;
    store_next = 1'b0;
    ignored_next = 1'b0;
    case (state_reg)
      M_IDLE: begin
        if (start_in) begin
          trig_idx_next = '0;
          store_idx_next = '0;
          state_next = M_WAIT;
        end
      end
      M_WAIT: begin
        // bus trigger only on line source
        if (src_line_in && in_fall) begin
          if (trig_idx_reg >= list_len_in - 1'b1) begin
            trig_idx_next = '0;
            ignored_next = 1'b1;
          end else begin
            trig_idx_next = trig_idx_reg + 1'b1;
            timer_next = TIMER_W'(MEASURE_CYCLES - 1);
            state_next = M_MEAS;
          end
        end
      end
      M_MEAS: begin
        if (timer_reg == '0) begin
          store_next = (store_idx_reg < CNT_W'(STORE_DEPTH));
          store_idx_next = store_idx_reg + 1'b1;
          // measure output always on line source
          oe_n_next[out_line_in - 1'b1] = 1'b0;
          timer_next = TIMER_W'(PULSE_CYCLES - 1);
          state_next = M_OUT;
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      M_OUT: begin
        if (timer_reg == '0) begin
          state_next = M_WAIT;
        end else begin
          oe_n_next[out_line_in - 1'b1] = 1'b0;
          timer_next = timer_reg - 1'b1;
        end
      end
      default: begin
        state_next = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_reg <= M_IDLE;
      oe_n_reg <= ALL_RELEASED;
      timer_reg <= '0;
      trig_idx_reg <= '0;
      store_idx_reg <= '0;
      store_reg <= 1'b0;
      ignored_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      oe_n_reg <= oe_n_next;
      timer_reg <= timer_next;
      trig_idx_reg <= trig_idx_next;
      store_idx_reg <= store_idx_next;
      store_reg <= store_next;
      ignored_reg <= ignored_next;
    end
  end

  assign bus.oth_out = '0;
  assign bus.oth_oe_n = oe_n_reg;
  assign store_out = store_reg;
  assign store_idx_out = store_idx_reg;
  assign ignored_out = ignored_reg;
  assign waiting_out = (state_reg == M_WAIT);
endmodule
`default_nettype wire

//--- tb/trig_bus_checker.sv
`timescale 1ns/1ps
`default_nettype none
module trig_bus_checker #(
  parameter int PULSE_CYCLES = 4,
  parameter int MEASURE_CYCLES = 8
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Wired trigger lines.
  input wire logic [trig_seq_pkg::NUM_LINES-1:0] dev_out,
  input wire logic [trig_seq_pkg::NUM_LINES-1:0] dev_oe_n,
  input wire logic [trig_seq_pkg::NUM_LINES-1:0] oth_out,
  input wire logic [trig_seq_pkg::NUM_LINES-1:0] oth_oe_n,
  input wire logic [trig_seq_pkg::NUM_LINES-1:0] line
);
  import trig_seq_pkg::*;
  logic [15:0] dev_low_reg, dev_low_next, oth_low_reg, oth_low_next, since_reg, since_next;
  logic [NUM_LINES-1:0] prev_reg, prev_next;

  // Low-time counters and cycles since the meter trigger line last fell.
  always_comb begin
    dev_low_next = dev_oe_n[1] ? 16'h0000 : dev_low_reg + 16'h0001;
    oth_low_next = oth_oe_n[0] ? 16'h0000 : oth_low_reg + 16'h0001;
    since_next = (since_reg == 16'hFFFF) ? since_reg : since_reg + 16'h0001;
    if (prev_reg[1] && !line[1]) begin
      since_next = 16'h0001;
    end
    prev_next = line;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      dev_low_reg <= 16'h0000;
      oth_low_reg <= 16'h0000;
      since_reg <= 16'hFFFF;
      prev_reg <= ALL_RELEASED;
    end else begin
      dev_low_reg <= dev_low_next;
      oth_low_reg <= oth_low_next;
      since_reg <= since_next;
      prev_reg <= prev_next;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_scan_pulse_width: assert property ($rose(dev_oe_n[1]) |-> dev_low_reg == PULSE_CYCLES)
    else $error("scanner trigger pulse width wrong");
  chk_meter_pulse_width: assert property ($rose(oth_oe_n[0]) |-> oth_low_reg == PULSE_CYCLES)
    else $error("meter reply pulse width wrong");
  chk_open_drain: assert property (dev_out == '0 && oth_out == '0)
    else $error("driven level not low");
  chk_reset_release: assert property (disable iff (1'b0) !nrst_in |=>
    dev_oe_n == ALL_RELEASED && oth_oe_n == ALL_RELEASED)
    else $error("lines not released after reset");
  chk_meter_delay: assert property ($fell(oth_oe_n[0]) |->
    since_reg >= MEASURE_CYCLES && since_reg <= MEASURE_CYCLES + 8)
    else $error("meter reply timing wrong");
  chk_no_overlap: assert property (!(!dev_oe_n[1] && !oth_oe_n[0]))
    else $error("trigger and reply overlap");
  chk_meter_one_line: assert property (oth_oe_n[5:1] == 5'h1F)
    else $error("meter drove a foreign line");
  chk_scan_out_lines: assert property (dev_oe_n[0] && dev_oe_n[2] && dev_oe_n[4])
    else $error("scanner drove an input line");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import trig_seq_pkg::*;
  logic clk, nrst, step_a, step_b, start_m, byp, src, b_arm_byp;
  logic [NUM_LINES-1:0] pull_n, prev;
  logic [LINE_NUM_W-1:0] l1, l2, l3, l4, l5, l6;
  logic [CNT_W-1:0] cnt1, cnt2, len;
  logic a_close, a_open, a_idle, a_armw, b_close, b_open, b_idle, b_armw;
  logic m_store, m_ign, m_wait;
  logic [CNT_W-1:0] a_idx, b_idx, m_idx;
  int n_mismatch, check_count, closes_a, closes_b, idx_a, idx_b, stores, ignores;
  int falls [NUM_LINES];
  trig_bus_if if_a ();
  trig_bus_if if_b ();
  // Scanner B is ANDed onto the first bus; the second bus mirrors the same wired level.
  assign if_a.aux_oe_n = if_b.dev_oe_n & pull_n;
  assign if_b.oth_oe_n = if_a.dev_oe_n & if_a.oth_oe_n & pull_n;
  assign if_b.aux_oe_n = ALL_RELEASED;
  assign if_b.oth_out = '0;

  scan_sequencer #(.SETTLE_CYCLES(4), .PULSE_CYCLES(4)) scan_sequencer_inst (
    .ref_clk_in(clk), .nrst_in(nrst), .bus(if_a), .step_in(step_a),
    .arm_src_line_in(src), .scan_src_line_in(src), .chan_src_line_in(src),
    .arm_bypass_in(byp), .scan_bypass_in(byp), .chan_bypass_in(byp),
    .arm_in_line_in(l5), .arm_out_line_in(l6), .scan_in_line_in(l3), .scan_out_line_in(l4),
    .chan_in_line_in(l1), .chan_out_line_in(l2), .arm_count_in(cnt1), .scan_count_in(cnt2),
    .list_len_in(len), .close_out(a_close), .close_idx_out(a_idx), .all_open_out(a_open),
    .idle_out(a_idle), .arm_wait_out(a_armw), .scan_wait_out());
  scan_sequencer #(.SETTLE_CYCLES(4), .PULSE_CYCLES(4)) scan_sequencer_b_inst (
    .ref_clk_in(clk), .nrst_in(nrst), .bus(if_b), .step_in(step_b),
    .arm_src_line_in(src), .scan_src_line_in(src), .chan_src_line_in(src),
    .arm_bypass_in(b_arm_byp), .scan_bypass_in(byp), .chan_bypass_in(byp),
    .arm_in_line_in(l4), .arm_out_line_in(l3), .scan_in_line_in(l4), .scan_out_line_in(l3),
    .chan_in_line_in(l1), .chan_out_line_in(l2), .arm_count_in(cnt2), .scan_count_in(cnt1),
    .list_len_in(len), .close_out(b_close), .close_idx_out(b_idx), .all_open_out(b_open),
    .idle_out(b_idle), .arm_wait_out(b_armw), .scan_wait_out());
  meter_trigger_end #(.MEASURE_CYCLES(8), .PULSE_CYCLES(4)) meter_trigger_end_inst (
    .ref_clk_in(clk), .nrst_in(nrst), .bus(if_a), .start_in(start_m), .src_line_in(src),
    .in_line_in(l2), .out_line_in(l1), .list_len_in(len), .store_out(m_store),
    .store_idx_out(m_idx), .ignored_out(m_ign), .waiting_out(m_wait));
  trig_bus_checker #(.PULSE_CYCLES(4), .MEASURE_CYCLES(8)) trig_bus_checker_inst (
    .ref_clk_in(clk), .nrst_in(nrst), .dev_out(if_a.dev_out), .dev_oe_n(if_a.dev_oe_n),
    .oth_out(if_a.oth_out), .oth_oe_n(if_a.oth_oe_n), .line(if_a.line));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Follows list order and the dummy flag of each closed channel, and counts line falls.
  always @(posedge clk) begin
    if (nrst) begin
      if (a_close) begin
        check(32'(a_idx), idx_a);
        check(32'(a_open), 32'(idx_a == len - 1));
        idx_a = (idx_a + 1) % len;
        closes_a++;
      end
      if (b_close) begin
        check(32'(b_idx), idx_b);
        check(32'(b_open), 32'(idx_b == len - 1));
        idx_b = (idx_b + 1) % len;
        closes_b++;
      end
      stores += m_store;
      ignores += m_ign;
      for (int i = 0; i < NUM_LINES; i++) begin
        falls[i] += prev[i] & ~if_a.line[i];
      end
    end
    prev = if_a.line;
  end

  // Counts that only appear when every layer takes its triggers from the lines.
  function automatic int on_line(input logic s, input int v);
    return s ? v : 0;
  endfunction

  task automatic run(input int r, input int l, input int n, input logic s);
    int t;
    nrst <= 1'b0;
    len <= l[CNT_W-1:0];
    cnt2 <= n[CNT_W-1:0];
    src <= s;
    byp <= s | 1'($urandom % 2);
    repeat (5) @(posedge clk);
    closes_a = 0; closes_b = 0; idx_a = 0; idx_b = 0; stores = 0; ignores = 0;
    foreach (falls[i]) falls[i] = 0;
    nrst <= 1'b1;
    start_m <= 1'b1;
    step_b <= 1'b1;
    @(posedge clk);
    start_m <= 1'b0;
    step_b <= 1'b0;
    repeat (10) @(posedge clk);
    check(32'(b_armw), 32'(s));
    check(32'(b_idle), 0);
    // A trigger on a line that no waiting layer listens to must be ignored.
    pull_n <= 6'h2F;
    repeat (6) @(posedge clk);
    pull_n <= ALL_RELEASED;
    repeat (10) @(posedge clk);
    check(32'(b_armw), 32'(s));
    check(closes_a, 0);
    check(32'(closes_b == 0), 32'(s));
    repeat ($urandom % 8) @(posedge clk);
    step_a <= 1'b1;
    @(posedge clk);
    step_a <= 1'b0;
    t = 0;
    while (!a_close && t < 10) begin
      @(posedge clk);
      t++;
    end
    check(32'(t <= 6), 1);
    t = 0;
    while (!(a_idle && b_idle && closes_a == n * l && closes_b == n * l) && t < 5000) begin
      @(posedge clk);
      t++;
    end
    check(32'(t < 5000), 1);
    repeat (20) @(posedge clk);
    check(closes_a, n * l);
    check(closes_b, n * l);
    check(32'(a_idle && b_idle), 1);
    check(stores, on_line(s, 2 * n * (l - 1)));
    check(32'(m_idx), on_line(s, 2 * n * (l - 1)));
    check(ignores, on_line(s, 2 * n));
    check(falls[1], on_line(s, 2 * n * l));
    check(falls[0], on_line(s, 2 * n * (l - 1)));
    check(falls[3], on_line(s, n));
    check(falls[2], on_line(s, n));
    check(falls[5], on_line(s, 1));
    check(32'(m_wait), 1);
    $display("test %0d done, list length %0d, passes %0d, line source %0d", r, l, n, s);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    nrst = 1'b0; step_a = 1'b0; step_b = 1'b0; start_m = 1'b0; pull_n = ALL_RELEASED;
    byp = 1'b1; src = 1'b1; b_arm_byp = 1'b0; cnt1 = 8'h01; cnt2 = 8'h02; len = 8'h02;
    l1 = LINE_METER_DONE; l2 = LINE_METER_TRIG; l3 = LINE_HAND_BACK;
    l4 = LINE_HAND_OVER; l5 = LINE_ARM_A_IN; l6 = LINE_ARM_A_OUT;
    n_mismatch = 0; check_count = 0;
    void'($urandom(32'hFE5355E5));
    run(0, 2, 2, 1'b1);
    // Run two uses immediate sources: no scanner layer waits and only the bench pulse on line 5 may move.
    for (int r = 1; r < 4; r++) begin
      run(r, 2 + int'($urandom % 4), 1 + int'($urandom % 3), logic'(r != 2));
    end
    test_done();
  end

  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
